//--- design/amp_pkg.sv
package amp_pkg;

  // ***********************************************************
  // opcode pages and prebytes
  // ***********************************************************
  localparam logic [7:0] PRE_PAGE2 = 8'h18;
  localparam logic [7:0] PRE_PAGE3 = 8'h1a;
  localparam logic [7:0] PRE_PAGE4 = 8'hcd;

  // ***********************************************************
  // opcodes held by this decoder
  // ***********************************************************
  localparam logic [7:0] OP_ADD_B_INTO_A     = 8'h1b;
  localparam logic [7:0] OP_ADD_B_INTO_INDEX = 8'h3a;
  localparam logic [7:0] OP_SHIFT_LEFT_DBL   = 8'h05;
  localparam logic [7:0] OP_ADD16_IMM        = 8'hc3;
  localparam logic [7:0] OP_ADD16_DIR        = 8'hd3;
  localparam logic [7:0] OP_ADD16_EXT        = 8'hf3;
  localparam logic [7:0] OP_ADD16_IDX        = 8'he3;
  localparam logic [7:0] OP_BRA              = 8'h20;
  localparam logic [3:0] BR_HI_NIB           = 4'h2;

  // ***********************************************************
  // cycle counts and address constants
  // ***********************************************************
  localparam logic [3:0] CYC_ABA      = 4'h2;
  localparam logic [3:0] CYC_ABX      = 4'h3;
  localparam logic [3:0] CYC_SHIFT_LEFT_DOUBLE     = 4'h3;
  localparam logic [3:0] CYC_ADD_IMM  = 4'h4;
  localparam logic [3:0] CYC_ADD_DIR  = 4'h5;
  localparam logic [3:0] CYC_ADD_EXT  = 4'h6;
  localparam logic [3:0] CYC_ADD_IDX  = 4'h6;
  localparam logic [3:0] CYC_BRANCH   = 4'h3;
  localparam logic [3:0] CYC_Y_EXTRA  = 4'h1;
  localparam logic [3:0] CYC_UNKNOWN  = 4'h2;
  localparam logic [7:0] DIRECT_PAGE  = 8'h00;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [15:0] PC_STEP     = 16'h0001;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [2:0] {
    AMP_INH, AMP_IMM, AMP_DIR, AMP_EXT, AMP_IDX, AMP_REL
  } amp_mode_t;

  typedef enum logic [1:0] {
    AMP_PAGE1, AMP_PAGE2, AMP_PAGE3, AMP_PAGE4
  } amp_page_t;

  typedef struct packed {
    logic [7:0]  data;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
  } amp_bus_t;

  typedef struct packed {
    logic c;
    logic v;
    logic z;
    logic n;
  } amp_ccr_t;

endpackage

//--- design/amp_alu.sv
`timescale 1ns/1ps
// ***********************************************************
// adder for effective addresses and 16-bit sums
// ***********************************************************
module amp_alu
  import amp_pkg::*;
(
  // operands
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  // result
  output logic      [15:0] sum_o,
  output logic             carry_o
);
  assign {carry_o, sum_o} = {1'b0, a_i} + {1'b0, b_i};
endmodule // amp_alu

//--- design/amp_decoder.sv
`timescale 1ns/1ps
// Contract
// - extended: next two bytes form address
// - indexed: index plus unsigned offset byte
// - indexed reaches whole 64k space
// - inherent: no memory operand access
// - branch adds signed offset when taken
// - prebytes select opcode pages two to four
// - no prebyte means page one decode
// - exact tabulated cycle count per instruction
// - same mode and count, same sequence
// - opcode 1b adds b into a
// - opcode 3a adds b to first index
// - 18 3a adds b to second index
// - sixteen-bit add of memory into d
// - opcode 05 shifts d left, carry
// - direct mode high byte forced zero
// - second index costs one byte, cycle
module amp_decoder
  import amp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // memory bus
  input  wire logic [7:0]  rdata_i,
  output amp_bus_t         bus_o,
  // branch condition from flags
  input  wire logic        br_cond_i,
  // visible state
  output logic [7:0]       acc_a_o,
  output logic [7:0]       acc_b_o,
  output logic [15:0]      first_index_reg_o,
  output logic [15:0]      second_index_reg_o,
  output logic [15:0]      pc_o,
  output amp_ccr_t         ccr_o,
  output amp_mode_t        mode_o,
  output amp_page_t        page_o,
  output logic             instr_done_o,
  output logic             illegal_o
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef enum {
    ST_FETCH, ST_OPCODE, ST_OPND_HI, ST_OPND_LO, ST_MEM_HI,
    ST_MEM_LO, ST_EXEC
  } amp_state_t;

  amp_state_t  st_q, st_d;
  amp_page_t   page_q, page_d, pg_w;
  amp_mode_t   mode_q, mode_d;
  logic [7:0]  op_q, op_d, a_q, a_d, b_q, b_d, lo_q, lo_d, hi_q, hi_d;
  logic [15:0] x_q, x_d, y_q, y_d, pc_q, pc_d, ea_q, ea_d;
  amp_ccr_t    ccr_q, ccr_d;
  logic [3:0]  cyc_q, cyc_d;
  logic [3:0]  tot_q, tot_d;
  amp_bus_t    bus_q, bus_d;
  logic        done_q, done_d, ill_q, ill_d;

  logic [15:0] add_a, add_b, add_s;
  logic        add_c;

  amp_alu u_alu (
    .a_i    (add_a),
    .b_i    (add_b),
    .sum_o  (add_s),
    .carry_o(add_c)
  );

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic amp_mode_t mode_of(input logic [7:0] op);
    if (op == OP_ADD16_IMM) mode_of = AMP_IMM;
    else if (op == OP_ADD16_DIR) mode_of = AMP_DIR;
    else if (op == OP_ADD16_EXT) mode_of = AMP_EXT;
    else if (op == OP_ADD16_IDX) mode_of = AMP_IDX;
    else if (op[7:4] == BR_HI_NIB) mode_of = AMP_REL;
    else mode_of = AMP_INH;
  endfunction

  function automatic logic [3:0] cycles_of(input logic [7:0] op,
                                           input amp_page_t pg);
    logic [3:0] c;
    c = CYC_UNKNOWN;
    case (op)
      OP_ADD_B_INTO_A:     c = CYC_ABA;
      OP_ADD_B_INTO_INDEX: c = CYC_ABX;
      OP_SHIFT_LEFT_DBL:   c = CYC_SHIFT_LEFT_DOUBLE;
      OP_ADD16_IMM:        c = CYC_ADD_IMM;
      OP_ADD16_DIR:        c = CYC_ADD_DIR;
      OP_ADD16_EXT:        c = CYC_ADD_EXT;
      OP_ADD16_IDX:        c = CYC_ADD_IDX;
      default:             c = (op[7:4] == BR_HI_NIB) ? CYC_BRANCH
                                                      : CYC_UNKNOWN;
    endcase
    if (pg == AMP_PAGE2)
      c = c + CYC_Y_EXTRA;
    cycles_of = c;
  endfunction

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    st_d = st_q; page_d = page_q; mode_d = mode_q; op_d = op_q;
    a_d = a_q; b_d = b_q; lo_d = lo_q; hi_d = hi_q;
    x_d = x_q; y_d = y_q; pc_d = pc_q; ea_d = ea_q; ccr_d = ccr_q;
    tot_d = tot_q; done_d = 1'b0; ill_d = ill_q;
    pg_w = (cyc_q == 4'h0) ? AMP_PAGE1 : page_q;
    cyc_d = cyc_q + 4'h1;
    bus_d = '0;
    add_a = pc_q;
    add_b = PC_STEP;
    case (st_q)
      ST_FETCH: begin
        bus_d.addr = pc_q;
        bus_d.rd   = 1'b1;
        st_d       = ST_OPCODE;
        cyc_d      = 4'h0;
        page_d     = AMP_PAGE1;
      end
      ST_OPCODE: begin
        pc_d       = add_s;
        bus_d.addr = add_s;
        bus_d.rd   = 1'b1;
        if (rdata_i == PRE_PAGE2 && pg_w == AMP_PAGE1) begin
          page_d = AMP_PAGE2;
        end else if (rdata_i == PRE_PAGE3 && pg_w == AMP_PAGE1) begin
          page_d = AMP_PAGE3;
        end else if (rdata_i == PRE_PAGE4 && pg_w == AMP_PAGE1) begin
          page_d = AMP_PAGE4;
        end else begin
          page_d = pg_w;
          ill_d  = (pg_w == AMP_PAGE3) || (pg_w == AMP_PAGE4) ||
                   (cycles_of(rdata_i, AMP_PAGE1) == CYC_UNKNOWN &&
                    rdata_i != OP_ADD_B_INTO_A);
          op_d   = ill_d ? '0 : rdata_i;
          mode_d = ill_d ? AMP_INH : mode_of(rdata_i);
          tot_d  = ill_d ? CYC_UNKNOWN : cycles_of(rdata_i, pg_w);
          st_d   = ST_OPND_HI;
          if (mode_d == AMP_INH) begin
            bus_d = '0;
            st_d  = ST_EXEC;
          end
        end
      end
      ST_OPND_HI: begin
        pc_d = add_s;
        hi_d = rdata_i;
        lo_d = rdata_i;
        st_d = ST_EXEC;
        case (mode_q)
          AMP_EXT, AMP_IMM: begin
            bus_d.addr = add_s;
            bus_d.rd   = 1'b1;
            st_d       = ST_OPND_LO;
          end
          AMP_DIR: begin
            ea_d = {DIRECT_PAGE, rdata_i};
            st_d = ST_MEM_HI;
          end
          AMP_IDX: begin
            add_a = (page_q == AMP_PAGE2) ? y_q : x_q;
            add_b = {8'h00, rdata_i};
            ea_d  = add_s;
            pc_d  = pc_q + PC_STEP;
            st_d  = ST_MEM_HI;
          end
          default: st_d = ST_EXEC;
        endcase
      end
      ST_OPND_LO: begin
        pc_d = add_s;
        lo_d = rdata_i;
        ea_d = {hi_q, rdata_i};
        st_d = (mode_q == AMP_IMM) ? ST_EXEC : ST_MEM_HI;
      end
      ST_MEM_HI: begin
        bus_d.addr = ea_q;
        bus_d.rd   = 1'b1;
        add_a = ea_q;
        ea_d  = add_s;
        st_d  = ST_MEM_LO;
      end
      ST_MEM_LO: begin
        hi_d = rdata_i;
        bus_d.addr = ea_q;
        bus_d.rd   = 1'b1;
        st_d = ST_EXEC;
      end
      ST_EXEC: begin
        lo_d = bus_q.rd ? rdata_i : lo_q;
        if (cyc_q + 4'h1 >= tot_q) begin
          done_d = 1'b1;
          st_d   = ST_OPCODE;
          cyc_d  = 4'h0;
          case (op_q)
            OP_ADD_B_INTO_A: begin
              add_a = {8'h00, a_q};
              add_b = {8'h00, b_q};
              a_d   = add_s[7:0];
              ccr_d.c = add_s[8];
              ccr_d.n = add_s[7];
              ccr_d.z = (add_s[7:0] == 8'h00);
              ccr_d.v = (a_q[7] == b_q[7]) && (add_s[7] != a_q[7]);
            end
            OP_ADD_B_INTO_INDEX: begin
              add_a = (page_q == AMP_PAGE2) ? y_q : x_q;
              add_b = {8'h00, b_q};
              if (page_q == AMP_PAGE2) y_d = add_s;
              else x_d = add_s;
            end
            OP_SHIFT_LEFT_DBL: begin
              ccr_d.c = a_q[7];
              {a_d, b_d} = {a_q[6:0], b_q, 1'b0};
              ccr_d.n = a_q[6];
              ccr_d.z = ({a_q[6:0], b_q} == 15'h0000);
              ccr_d.v = a_q[7] ^ a_q[6];
            end
            OP_ADD16_IMM, OP_ADD16_DIR, OP_ADD16_EXT, OP_ADD16_IDX: begin
              add_a = {a_q, b_q};
              add_b = {hi_q, lo_d};
              {a_d, b_d} = add_s;
              ccr_d.c = add_c;
              ccr_d.n = add_s[15];
              ccr_d.z = (add_s == 16'h0000);
              ccr_d.v = (a_q[7] == add_b[15]) && (add_s[15] != a_q[7]);
            end
            default: begin
              if (mode_q == AMP_REL && (br_cond_i || op_q == OP_BRA)) begin
                add_a = pc_q;
                add_b = {{8{lo_q[7]}}, lo_q};
                pc_d  = add_s;
              end
            end
          endcase
          bus_d.addr = pc_d;
          bus_d.rd   = 1'b1;
        end
      end
      default: st_d = ST_FETCH;
    endcase
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q <= ST_FETCH; page_q <= AMP_PAGE1; mode_q <= AMP_INH;
      op_q <= 8'h00; a_q <= 8'h00; b_q <= 8'h00;
      lo_q <= 8'h00; hi_q <= 8'h00;
      x_q <= 16'h0000; y_q <= 16'h0000; pc_q <= RESET_PC;
      ea_q <= 16'h0000; ccr_q <= '0; cyc_q <= 4'h0; tot_q <= 4'h0;
      bus_q <= '0; done_q <= 1'b0; ill_q <= 1'b0;
    end else begin
      st_q <= st_d; page_q <= page_d; mode_q <= mode_d;
      op_q <= op_d; a_q <= a_d; b_q <= b_d;
      lo_q <= lo_d; hi_q <= hi_d;
      x_q <= x_d; y_q <= y_d; pc_q <= pc_d;
      ea_q <= ea_d; ccr_q <= ccr_d; cyc_q <= cyc_d; tot_q <= tot_d;
      bus_q <= bus_d; done_q <= done_d; ill_q <= ill_d;
    end
  end

  assign bus_o              = bus_q;
  assign acc_a_o            = a_q;
  assign acc_b_o            = b_q;
  assign first_index_reg_o  = x_q;
  assign second_index_reg_o = y_q;
  assign pc_o               = pc_q;
  assign ccr_o              = ccr_q;
  assign mode_o             = mode_q;
  assign page_o             = page_q;
  assign instr_done_o       = done_q;
  assign illegal_o          = ill_q;

endmodule // amp_decoder

//--- tb/amp_mem_model.sv
`timescale 1ns/1ps
module amp_mem_model
  import amp_pkg::*;
(
  // clock and bus
  input  wire logic     clk_sys_i,
  input  wire amp_bus_t bus_i,
  // read data
  output logic [7:0]    rdata_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  // ****
  // read path
  // ****
  always_ff @(posedge clk_sys_i) begin
    addr_q <= bus_i.addr;
  end
  // byte at M then M+1, one read each
  // released bus shows the inverse so stale data never matches
  always_comb begin
    if (bus_i.rd)
      rdata_o = mem[bus_i.addr];
    else
      rdata_o = ~mem[addr_q];
  end
endmodule // amp_mem_model

//--- tb/amp_decoder_monitor.sv
`timescale 1ns/1ps
module amp_decoder_monitor
  import amp_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  // observed outputs
  input wire amp_bus_t    bus_o,
  input wire logic [7:0]  acc_a_o,
  input wire logic [7:0]  acc_b_o,
  input wire logic [15:0] first_index_reg_o,
  input wire logic [15:0] second_index_reg_o,
  input wire logic [15:0] pc_o,
  input wire amp_mode_t   mode_o,
  input wire amp_page_t   page_o,
  input wire logic        instr_done_o,
  input wire logic        illegal_o
);
  logic [15:0] pc_q, x_q, y_q, d_q;
  logic [7:0]  cyc_q, cyc_d;
  logic        seen_q, seen_d, fin;
  // first end after reset has no reference point
  assign fin = instr_done_o & seen_q & ~illegal_o;
  always_comb begin
    cyc_d  = instr_done_o ? 8'h01 : cyc_q + 8'h01;
    seen_d = seen_q | instr_done_o;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cyc_q  <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      cyc_q  <= cyc_d;
      seen_q <= seen_d;
    end
    if (instr_done_o) begin
      pc_q <= pc_o;
      x_q  <= first_index_reg_o;
      y_q  <= second_index_reg_o;
      d_q  <= {acc_a_o, acc_b_o};
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_no_store: assert property (
    bus_o.wr == 1'b0) else $error("store seen");
  a_done_pulse: assert property (
    instr_done_o |=> !instr_done_o) else $error("done too long");
  a_inh_len: assert property (
    fin && mode_o == AMP_INH && page_o == AMP_PAGE1 |->
    pc_o == pc_q + 16'h0001 && cyc_q inside {[8'h02:8'h03]})
    else $error("inherent length");
  a_aby_len: assert property (
    fin && mode_o == AMP_INH && page_o == AMP_PAGE2 |->
    pc_o == pc_q + 16'h0002 && cyc_q == 8'h04) else $error("prebyte len");
  a_ext_len: assert property (
    fin && mode_o == AMP_EXT |-> pc_o == pc_q + 16'h0003 && cyc_q == 8'h06)
    else $error("extended length");
  a_idx_len: assert property (
    fin && mode_o == AMP_IDX |->
    cyc_q == (page_o == AMP_PAGE2 ? 8'h07 : 8'h06)) else $error("idx cycles");
  a_dir_len: assert property (
    fin && mode_o == AMP_DIR |-> pc_o == pc_q + 16'h0002 && cyc_q == 8'h05)
    else $error("direct length");
  a_x_sum: assert property (
    fin && first_index_reg_o != x_q |->
    first_index_reg_o == x_q + {8'h00, acc_b_o}) else $error("x sum");
  a_y_sum: assert property (
    fin && second_index_reg_o != y_q |->
    second_index_reg_o == y_q + {8'h00, acc_b_o}) else $error("y sum");
  a_branch_keep: assert property (
    fin && mode_o == AMP_REL |-> {acc_a_o, acc_b_o} == d_q)
    else $error("branch changed d");
endmodule // amp_decoder_monitor

bind amp_decoder amp_decoder_monitor mon_u (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_o(bus_o),
  .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .pc_o(pc_o),
  .first_index_reg_o(first_index_reg_o),
  .second_index_reg_o(second_index_reg_o), .mode_o(mode_o),
  .page_o(page_o), .instr_done_o(instr_done_o), .illegal_o(illegal_o));

//--- tb/amp_decoder_tb.sv
`timescale 1ns/1ps
module amp_decoder_tb
  import amp_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        br_cond_i = 1'b0;
  logic [7:0]  rdata_i, acc_a_o, acc_b_o;
  logic [15:0] first_index_reg_o, second_index_reg_o, pc_o, d_w;
  logic        instr_done_o, illegal_o;
  amp_bus_t    bus_o;
  amp_ccr_t    ccr_o;
  amp_mode_t   mode_o;
  amp_page_t   page_o;
  int          n_mismatch = 0;
  int          checks = 0;
  assign d_w = {acc_a_o, acc_b_o};
  always #5 clk_sys_i = ~clk_sys_i;
  amp_mem_model mem_u (.clk_sys_i(clk_sys_i), .bus_i(bus_o),
    .rdata_o(rdata_i));
  amp_decoder dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .rdata_i(rdata_i), .bus_o(bus_o), .br_cond_i(br_cond_i),
    .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .pc_o(pc_o),
    .first_index_reg_o(first_index_reg_o), .ccr_o(ccr_o),
    .second_index_reg_o(second_index_reg_o), .mode_o(mode_o),
    .page_o(page_o), .instr_done_o(instr_done_o), .illegal_o(illegal_o));
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [167:0] s, input int n);
    for (int i = 0; i < n; i++)
      mem_u.mem[a + 16'(i)] = s[8*(n-1-i) +: 8];
  endtask
  // counts cycles since the previous instruction end
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (instr_done_o !== 1'b1 && n < 40);
    if (n >= 40) chk("done", 16'h0000, 16'h0001);
  endtask
  task automatic step(input logic [3:0] cyc, input logic [15:0] pc);
    int n;
    wait_done(n);
    if (cyc != 4'h0) chk("cycles", 16'(n), {12'h000, cyc});
    chk("pc", pc_o, pc);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task t_ops;
    step(4'h0, 16'h0001);
    chk("page", 16'(page_o), 16'(AMP_PAGE1));
    step(4'h4, 16'h0004);
    chk("d", d_w, 16'h92f4);
    step(4'h2, 16'h0005);
    chk("a", {8'h00, acc_a_o}, 16'h0086);
    step(4'h3, 16'h0006);
    chk("x", first_index_reg_o, 16'h00f4);
    step(4'h4, 16'h0008);
    chk("y", second_index_reg_o, 16'h00f4);
    step(4'h3, 16'h0009);
    chk("d", d_w, 16'h0de8);
    chk("c", {15'h0000, ccr_o.c}, 16'h0001);
  endtask
  task t_mem;
    step(4'h5, 16'h000b);
    chk("d", d_w, 16'h0eea);
    step(4'h6, 16'h000e);
    chk("d", d_w, 16'h1f0a);
    chk("mode", 16'(mode_o), 16'(AMP_EXT));
    step(4'h6, 16'h0010);
    chk("d", d_w, 16'h1f0b);
    step(4'h7, 16'h0013);
    chk("d", d_w, 16'h1f0e);
  endtask
  task t_branch;
    step(4'h3, 16'h0018);
    step(4'h3, 16'h001a);
    chk("d", d_w, 16'h1f0e);
    @(posedge clk_sys_i);
    br_cond_i <= 1'b1;
    step(4'h3, 16'hff9c);
  endtask
  task t_pages;
    int n;
    wait_done(n);
    chk("illegal", {15'h0000, illegal_o}, 16'h0001);
    chk("page", 16'(page_o), 16'(AMP_PAGE3));
    chk("x", first_index_reg_o, 16'h00f4);
    wait_done(n);
    chk("page", 16'(page_o), 16'(AMP_PAGE4));
    wait_done(n);
    chk("page", 16'(page_o), 16'(AMP_PAGE2));
    chk("y", second_index_reg_o, 16'h0102);
  endtask
  initial begin
    for (int i = 0; i < 65536; i++)
      mem_u.mem[i] = 8'h00;
    put(16'h0000, 168'h1bc392f41b3a183a05d340f38100e30518e3ff2003, 21);
    put(16'h0018, 32'h26fe2680, 4);
    put(16'hff9c, 48'h1a3acd3a183a, 6);
    put(16'h0040, 16'h0102, 2);
    put(16'h8100, 16'h1020, 2);
    put(16'h00f9, 16'h0001, 2);
    put(16'h01f3, 16'h0003, 2);
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_ops;
    t_mem;
    t_branch;
    t_pages;
    give_verdict;
  end
  // whole run needs about eighty cycles
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    n_mismatch++;
    give_verdict;
  end
endmodule // amp_decoder_tb
